/* File: src/option_cfg_pkg.sv */
// Constants, field layout and types for the option word decoder
// Functional notes
// - Option words sit outside program memory; the register bus never reaches them.
// - Word 0 bit 12 low makes the shared pin an active-low reset.
// - Word 0 bit 11 low enables the watchdog; high disables it.
// - Word 0 bit 10 picks two (0) or four (1) oscillator periods per instruction.
// - Reset level field: 11 power-on only, 10 2.7/2.9V, 01 3.5/3.7V, 00 4.0/4.0V.
// - Watchdog period field: 11 18ms, 10 4.5ms, 01 288ms, 00 72ms.
// - Filter width bit: 0 accepts 8/fc pulses, 1 accepts 32/fc pulses.
// - External interrupt pin triggers on falling edges, filtered when enabled.
// - Word 0 bit 3 enables the filter; watch crystal mode always disables it.
// - Each of three protect bits enables code protection when zero.
// - Word 1 bit 12 low selects low power, high selects high power.
// - RC frequency field: 11 4MHz, 10 16MHz, 01 8MHz, 00 1MHz.
// - Four-bit clock source field decodes to RC, crystal and watch modes.
// - Every crystal mode dedicates both crystal pins to the oscillator.
// - Internal RC mode frees the oscillator input pad for general I/O.
// - In RC modes with pad role, bit 0 picks open-drain or clock out.
// - Word 2 bit 11 picks a 128kHz (0) or 16kHz (1) sub-clock.
// - Word 2 bit 10 picks the 10-pin (0) or 14-pin (1) package.
// - Word 2 bits 9 to 0 carry a customer tag with no effect.
package option_cfg_pkg;
  localparam int WORD_W = 13;

  // Word 0 fields
  localparam int W0_RESET_PIN   = 12;
  localparam int W0_DOG_EN      = 11;
  localparam int W0_INSTR_PER   = 10;
  localparam int W0_LVR_HI      = 9;
  localparam int W0_LVR_LO      = 8;
  localparam int W0_DOG_PER_HI  = 6;
  localparam int W0_DOG_PER_LO  = 5;
  localparam int W0_NF_WIDTH    = 4;
  localparam int W0_NF_EN       = 3;
  localparam int W0_PROT_HI     = 2;
  localparam int W0_PROT_LO     = 0;

  // Word 1 fields
  localparam int W1_POWER       = 12;
  localparam int W1_RCF_HI      = 6;
  localparam int W1_RCF_LO      = 5;
  localparam int W1_SRC_HI      = 4;
  localparam int W1_SRC_LO      = 1;
  localparam int W1_PAD_MODE    = 0;

  // Word 2 fields
  localparam int W2_SLOW_CLK    = 11;
  localparam int W2_PACKAGE     = 10;
  localparam int W2_TAG_HI      = 9;
  localparam int W2_TAG_LO      = 0;

  localparam logic [WORD_W-1:0] WORD_ERASED = 13'h1fff;

  // Clock source codes
  localparam logic [3:0] SRC_EXT_RC_IO   = 4'h0;
  localparam logic [3:0] SRC_EXT_RC_OUT  = 4'h1;
  localparam logic [3:0] SRC_INT_RC_IO   = 4'h2;
  localparam logic [3:0] SRC_INT_RC_OUT  = 4'h3;
  localparam logic [3:0] SRC_LOW_XTAL    = 4'h4;
  localparam logic [3:0] SRC_HIGH_TOP    = 4'h5;
  localparam logic [3:0] SRC_WATCH       = 4'h6;
  localparam logic [3:0] SRC_HIGH_MID    = 4'h7;
  localparam logic [3:0] SRC_MEDIUM      = 4'hf;

  typedef enum logic [6:0] {
    ext_resistor_cap_osc  = 7'h01,
    on_chip_rc_osc        = 7'h02,
    low_crystal_mode_a    = 7'h04,
    high_crystal_mode_top = 7'h08,
    watch_crystal_mode    = 7'h10,
    high_crystal_mode_mid = 7'h20,
    medium_crystal_mode   = 7'h40
  } clock_mode_t;

  // Two-bit field codes
  localparam logic [1:0] CODE_11 = 2'h3;
  localparam logic [1:0] CODE_10 = 2'h2;
  localparam logic [1:0] CODE_01 = 2'h1;
  localparam logic [1:0] CODE_00 = 2'h0;

  // Low-voltage reset thresholds in mV, zero for power-on only
  localparam logic [12:0] LVR_NONE_MV   = 13'h0000;
  localparam logic [12:0] LVR_27_MV     = 13'ha8c;
  localparam logic [12:0] LVR_29_MV     = 13'hb54;
  localparam logic [12:0] LVR_35_MV     = 13'hdac;
  localparam logic [12:0] LVR_37_MV     = 13'he74;
  localparam logic [12:0] LVR_40_MV     = 13'hfa0;

  // Watchdog nominal periods in us
  localparam logic [18:0] DOG_18_US     = 19'h04650;
  localparam logic [18:0] DOG_4P5_US    = 19'h01194;
  localparam logic [18:0] DOG_288_US    = 19'h46500;
  localparam logic [18:0] DOG_72_US     = 19'h11940;

  // Frequencies in kHz
  localparam logic [13:0] RC_4M_KHZ     = 14'h0fa0;
  localparam logic [13:0] RC_16M_KHZ    = 14'h3e80;
  localparam logic [13:0] RC_8M_KHZ     = 14'h1f40;
  localparam logic [13:0] RC_1M_KHZ     = 14'h03e8;
  localparam logic [7:0]  SLOW_128_KHZ  = 8'h80;
  localparam logic [7:0]  SLOW_16_KHZ   = 8'h10;

  // Filter widths in fc periods
  localparam logic [5:0]  NF_SHORT_CYC  = 6'h08;
  localparam logic [5:0]  NF_LONG_CYC   = 6'h20;

  // Last count of the instruction divider (periods minus one)
  localparam logic [1:0]  INSTR_DIV2    = 2'h1;
  localparam logic [1:0]  INSTR_DIV4    = 2'h3;

  // Bus register map (byte addresses)
  localparam logic [7:0]  ADDR_INT_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_INT_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_PIN_STATUS = 8'h08;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
endpackage : option_cfg_pkg

/* File: src/option_word_config_decoder.sv */
// Option word latch, decoder, interrupt pin filter and bus slave
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
module option_word_config_decoder (
  input  wire logic                             mclk,
  input  wire logic                             rst,
  input  wire logic [option_cfg_pkg::WORD_W-1:0] otp_word0,
  input  wire logic [option_cfg_pkg::WORD_W-1:0] otp_word1,
  input  wire logic [option_cfg_pkg::WORD_W-1:0] otp_word2,
  input  wire logic                             ext_int_pin,
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic      [31:0]                      hrdata,
  output logic                                  hreadyout,
  output logic                                  hresp,
  output logic                                  reset_pin_is_reset,
  output logic                                  watchdog_enable,
  output logic      [18:0]                      dog_timeout_us,
  output logic                                  instr_cycle_en,
  output logic                                  lv_reset_enable,
  output logic      [12:0]                      lv_reset_mv,
  output logic      [12:0]                      lv_release_mv,
  output logic                                  noise_filter_active,
  output logic      [2:0]                       protect_enable,
  output logic                                  low_power_mode,
  output logic      [13:0]                      rc_freq_khz,
  output option_cfg_pkg::clock_mode_t           clock_mode,
  output logic                                  crystal_pins_dedicated,
  output logic                                  osc_input_pad_io,
  output logic                                  clock_out_pad_role,
  output logic                                  clock_out_pad_open_drain,
  output logic                                  clock_out_pad_drive_clock,
  output logic      [7:0]                       slow_clock_khz,
  output logic                                  package_is_14pin,
  output logic      [9:0]                       customer_tag_field,
  output logic                                  ext_int_event
);
  import option_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Option word capture
  logic [WORD_W-1:0] word0_meta, word1_meta, word2_meta;
  logic [WORD_W-1:0] word0_sync, word1_sync, word2_sync;
  logic [WORD_W-1:0] word0, word1, word2;

  always_ff @(posedge mclk) begin
    word0_meta <= otp_word0;
    word1_meta <= otp_word1;
    word2_meta <= otp_word2;
    word0_sync <= word0_meta;
    word1_sync <= word1_meta;
    word2_sync <= word2_meta;
  end

  // Sampled only while reset is held, frozen afterwards
  always_ff @(posedge mclk) begin
    if (rst) begin
      word0 <= word0_sync;
      word1 <= word1_sync;
      word2 <= word2_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  wire [1:0] lvr_code  = {word0[W0_LVR_HI], word0[W0_LVR_LO]};
  wire [1:0] dog_code  = {word0[W0_DOG_PER_HI], word0[W0_DOG_PER_LO]};
  wire [1:0] rcf_code  = {word1[W1_RCF_HI], word1[W1_RCF_LO]};
  wire [3:0] src_code  = word1[W1_SRC_HI:W1_SRC_LO];

  wire [12:0] next_lv_reset_mv =
    (lvr_code == CODE_10) ? LVR_27_MV :
    (lvr_code == CODE_01) ? LVR_35_MV :
    (lvr_code == CODE_00) ? LVR_40_MV : LVR_NONE_MV;
  wire [12:0] next_lv_release_mv =
    (lvr_code == CODE_10) ? LVR_29_MV :
    (lvr_code == CODE_01) ? LVR_37_MV :
    (lvr_code == CODE_00) ? LVR_40_MV : LVR_NONE_MV;

  wire [18:0] next_dog_timeout_us =
    (dog_code == CODE_11) ? DOG_18_US :
    (dog_code == CODE_10) ? DOG_4P5_US :
    (dog_code == CODE_01) ? DOG_288_US : DOG_72_US;

  wire [13:0] next_rc_freq_khz =
    (rcf_code == CODE_11) ? RC_4M_KHZ :
    (rcf_code == CODE_10) ? RC_16M_KHZ :
    (rcf_code == CODE_01) ? RC_8M_KHZ : RC_1M_KHZ;

  // Unlisted codes fall back to the erased-word mode
  clock_mode_t next_clock_mode;
  always_comb begin
    unique case (src_code)
      SRC_EXT_RC_IO, SRC_EXT_RC_OUT: next_clock_mode = ext_resistor_cap_osc;
      SRC_INT_RC_IO, SRC_INT_RC_OUT: next_clock_mode = on_chip_rc_osc;
      SRC_LOW_XTAL:                  next_clock_mode = low_crystal_mode_a;
      SRC_HIGH_TOP:                  next_clock_mode = high_crystal_mode_top;
      SRC_WATCH:                     next_clock_mode = watch_crystal_mode;
      SRC_HIGH_MID:                  next_clock_mode = high_crystal_mode_mid;
      default:                       next_clock_mode = medium_crystal_mode;
    endcase
  end

  wire rc_mode      = (next_clock_mode == ext_resistor_cap_osc) ||
                      (next_clock_mode == on_chip_rc_osc);
  wire pad_role     = rc_mode && src_code[0];
  wire filter_on    = word0[W0_NF_EN] && (next_clock_mode != watch_crystal_mode);
  wire [5:0] filter_len = word0[W0_NF_WIDTH] ? NF_LONG_CYC : NF_SHORT_CYC;

  always_ff @(posedge mclk) begin
    reset_pin_is_reset        <= ~word0[W0_RESET_PIN];
    watchdog_enable           <= ~word0[W0_DOG_EN];
    dog_timeout_us            <= next_dog_timeout_us;
    lv_reset_enable           <= (lvr_code != CODE_11);
    lv_reset_mv               <= next_lv_reset_mv;
    lv_release_mv             <= next_lv_release_mv;
    noise_filter_active       <= filter_on;
    protect_enable            <= ~word0[W0_PROT_HI:W0_PROT_LO];
    low_power_mode            <= ~word1[W1_POWER];
    rc_freq_khz               <= next_rc_freq_khz;
    clock_mode                <= next_clock_mode;
    crystal_pins_dedicated    <= ~rc_mode;
    osc_input_pad_io          <= (next_clock_mode == on_chip_rc_osc);
    clock_out_pad_role        <= pad_role;
    clock_out_pad_open_drain  <= pad_role && ~word1[W1_PAD_MODE];
    clock_out_pad_drive_clock <= pad_role && word1[W1_PAD_MODE];
    slow_clock_khz            <= word2[W2_SLOW_CLK] ? SLOW_16_KHZ : SLOW_128_KHZ;
    package_is_14pin          <= word2[W2_PACKAGE];
    customer_tag_field        <= word2[W2_TAG_HI:W2_TAG_LO];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle enable
  logic [1:0] instr_cnt;
  wire  [1:0] instr_last = word0[W0_INSTR_PER] ? INSTR_DIV4 : INSTR_DIV2;
  wire        instr_wrap = (instr_cnt >= instr_last);

  always_ff @(posedge mclk) begin
    if (rst) begin
      instr_cnt      <= 2'h0;
      instr_cycle_en <= 1'b0;
    end else begin
      instr_cnt      <= instr_wrap ? 2'h0 : instr_cnt + 2'h1;
      instr_cycle_en <= instr_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt pin: sync, pulse filter, falling edge
  logic       int_meta, int_sync;
  logic       int_level;
  logic [5:0] nf_cnt;

  always_ff @(posedge mclk) begin
    int_meta <= ext_int_pin;
    int_sync <= int_meta;
  end

  // Level must differ for filter_len cycles before it is accepted
  wire nf_differs = (int_sync != int_level);
  wire nf_accept  = ~filter_on || (nf_differs && (nf_cnt == filter_len - 6'h01));
  wire int_fall   = nf_differs && nf_accept && int_level;

  always_ff @(posedge mclk) begin
    if (rst) begin
      int_level     <= 1'b1;
      nf_cnt        <= 6'h00;
      ext_int_event <= 1'b0;
    end else begin
      if (nf_accept) begin
        int_level <= int_sync;
      end
      nf_cnt        <= (nf_differs && ~nf_accept) ? nf_cnt + 6'h01 : 6'h00;
      ext_int_event <= int_fall;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: control, sticky edge flag, pin status
  logic       int_enable;
  logic       int_flag;
  logic       dp_write;
  logic [7:0] dp_addr;

  wire addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  wire [7:0] a_addr = {haddr[7:2], 2'h0};
  wire wr_ctrl   = dp_write && (dp_addr == ADDR_INT_CTRL);
  wire wr_status = dp_write && (dp_addr == ADDR_INT_STATUS);
  wire flag_set  = int_fall && int_enable;
  wire flag_clr  = wr_status && hwdata[0];
  wire [31:0] next_hrdata =
    (a_addr == ADDR_INT_CTRL)   ? {31'h0, int_enable} :
    (a_addr == ADDR_INT_STATUS) ? {31'h0, int_flag} :
    (a_addr == ADDR_PIN_STATUS) ? {30'h0, noise_filter_active, int_level} : 32'h0;

  // Option words have no bus path at all
  always_ff @(posedge mclk) begin
    if (rst) begin
      dp_write   <= 1'b0;
      dp_addr    <= 8'h00;
      hrdata     <= 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      int_enable <= 1'b0;
      int_flag   <= 1'b0;
    end else begin
      dp_write   <= addr_phase && hwrite;
      dp_addr    <= a_addr;
      hrdata     <= (addr_phase && !hwrite) ? next_hrdata : 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (wr_ctrl) begin
        int_enable <= hwdata[0];
      end
      int_flag   <= flag_set | (int_flag & ~flag_clr);
    end
  end

endmodule : option_word_config_decoder

/* File: tb/otp_programmer_model.sv */
// Model of the programmer that burns the three option words
`timescale 1ns/1ns
module otp_programmer_model (
  input  wire logic [12:0] raw0,
  input  wire logic [12:0] raw1,
  input  wire logic [12:0] raw2,
  output logic      [12:0] otp_word0,
  output logic      [12:0] otp_word1,
  output logic      [12:0] otp_word2
);
  assign otp_word0 = raw0 | 13'h0080;
  assign otp_word1 = raw1 | 13'h0f80;
  assign otp_word2 = raw2 | 13'h1000;
endmodule : otp_programmer_model

/* File: tb/option_cfg_asserts.sv */
// Port checker for the option word decoder
`timescale 1ns/1ns
module option_cfg_checker (
  input wire logic                        mclk,
  input wire logic                        rst,
  input wire logic [12:0]                 otp_word0,
  input wire logic [12:0]                 otp_word1,
  input wire logic                        reset_pin_is_reset,
  input wire logic                        watchdog_enable,
  input wire logic [18:0]                 dog_timeout_us,
  input wire logic                        instr_cycle_en,
  input wire logic                        lv_reset_enable,
  input wire logic                        noise_filter_active,
  input wire logic [2:0]                  protect_enable,
  input wire option_cfg_pkg::clock_mode_t clock_mode,
  input wire logic                        crystal_pins_dedicated,
  input wire logic                        osc_input_pad_io,
  input wire logic                        clock_out_pad_open_drain,
  input wire logic                        ext_int_event
);
  import option_cfg_pkg::*;
  logic [12:0] w0;
  logic [12:0] w1;
  // Words as they stood while reset was held
  always_ff @(posedge mclk) begin
    if (rst) begin
      w0 <= otp_word0;
      w1 <= otp_word1;
    end
  end
  function automatic logic [6:0] mode_of(input logic [3:0] c);
    if (c < 4'h2) return 7'h01;
    if (c < 4'h4) return 7'h02;
    if (c < 4'h8) return 7'h04 << (c - 4'h4);
    return 7'h40;
  endfunction : mode_of
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_gap2; !instr_cycle_en ##1 instr_cycle_en; endsequence
  sequence s_gap4; !instr_cycle_en [*3] ##1 instr_cycle_en; endsequence
  property p_rst_pin; reset_pin_is_reset == !w0[12]; endproperty
  property p_dog_en; watchdog_enable == !w0[11]; endproperty
  property p_instr; instr_cycle_en |=> if (w0[10]) s_gap4 else s_gap2; endproperty
  property p_lvr; lv_reset_enable == (w0[9:8] != 2'h3); endproperty
  property p_dog_per; dog_timeout_us == (w0[6:5] == 2'h3 ? 19'd18000 : w0[6:5] == 2'h2 ?
    19'd4500 : w0[6:5] == 2'h1 ? 19'd288000 : 19'd72000); endproperty
  property p_filter; noise_filter_active == (w0[3] && w1[4:1] != 4'h6); endproperty
  property p_protect; protect_enable == ~w0[2:0]; endproperty
  property p_mode; clock_mode == mode_of(w1[4:1]); endproperty
  property p_xtal; crystal_pins_dedicated == (w1[4:3] != 2'h0); endproperty
  property p_pad_io; osc_input_pad_io == (w1[4:2] == 3'h1); endproperty
  property p_od; clock_out_pad_open_drain == (w1[4:3] == 2'h0 && w1[1] && !w1[0]); endproperty
  property p_event; ext_int_event |=> !ext_int_event; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin role wrong");
  a_dog_en: assert property (p_dog_en) else $error("watchdog enable wrong");
  a_instr: assert property (p_instr) else $error("instruction period wrong");
  a_lvr: assert property (p_lvr) else $error("low voltage reset enable wrong");
  a_dog_per: assert property (p_dog_per) else $error("watchdog period wrong");
  a_filter: assert property (p_filter) else $error("filter enable wrong");
  a_protect: assert property (p_protect) else $error("protect bits wrong");
  a_mode: assert property (p_mode) else $error("clock mode wrong");
  a_xtal: assert property (p_xtal) else $error("crystal pin role wrong");
  a_pad_io: assert property (p_pad_io) else $error("input pad role wrong");
  a_od: assert property (p_od) else $error("open drain pad wrong");
  a_event: assert property (p_event) else $error("event pulse too long");
endmodule : option_cfg_checker
bind option_word_config_decoder option_cfg_checker chk_inst (.*);

/* File: tb/tb.sv */
// Self-checking bench for the option word decoder
`timescale 1ns/1ns
module tb;
  import option_cfg_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, ext_int_pin = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [12:0] raw0 = 13'h1fff, raw1 = 13'h1fff, raw2 = 13'h1fff;
  logic [12:0] otp_word0, otp_word1, otp_word2, lv_reset_mv, lv_release_mv;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'd11805, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [2:0]  protect_enable;
  logic        hready, hreadyout, hresp, reset_pin_is_reset, watchdog_enable, instr_cycle_en;
  logic        lv_reset_enable, noise_filter_active, low_power_mode, crystal_pins_dedicated;
  logic        osc_input_pad_io, clock_out_pad_role, clock_out_pad_open_drain;
  logic        clock_out_pad_drive_clock, package_is_14pin, ext_int_event;
  logic [18:0] dog_timeout_us;
  logic [13:0] rc_freq_khz;
  logic [7:0]  slow_clock_khz;
  logic [9:0]  customer_tag_field;
  clock_mode_t clock_mode;
  int          miscompares = 0, n_compared = 0, ev_cnt, ic_cnt;
  assign hready = hreadyout;
  otp_programmer_model otp_programmer_model_inst (.*);
  option_word_config_decoder option_word_config_decoder_inst (.*);
  initial begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (rst) begin
      ev_cnt <= 0;
      ic_cnt <= 0;
    end else begin
      ev_cnt <= ev_cnt + (ext_int_event === 1'b1);
      ic_cnt <= ic_cnt + (instr_cycle_en === 1'b1);
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [12:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[12:0];
  endfunction : rnd
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic check_cfg(input logic [12:0] w0, input logic [12:0] w1, input logic [12:0] w2);
    int lvr[4] = '{4000, 3500, 2700, 0};
    int rel[4] = '{4000, 3700, 2900, 0};
    int dog[4] = '{72000, 288000, 4500, 18000};
    int rcf[4] = '{1000, 8000, 16000, 4000};
    int src;
    int md;
    int rc;
    int n0;
    src = w1[4:1];
    md = src < 2 ? 1 : src < 4 ? 2 : src < 8 ? 4 << (src - 4) : 64;
    rc = src == 1 || src == 3;
    check("rst_pin", reset_pin_is_reset, !w0[12]);
    check("dog_en", watchdog_enable, !w0[11]);
    check("lvr_en", lv_reset_enable, w0[9:8] != 2'h3);
    check("lvr_mv", lv_reset_mv, lvr[w0[9:8]]);
    check("lvr_rel", lv_release_mv, rel[w0[9:8]]);
    check("dog_us", dog_timeout_us, dog[w0[6:5]]);
    check("nf_act", noise_filter_active, w0[3] && src != 6);
    check("protect", protect_enable, 3'h7 ^ w0[2:0]);
    check("low_pwr", low_power_mode, !w1[12]);
    check("rc_khz", rc_freq_khz, rcf[w1[6:5]]);
    check("mode", clock_mode, md);
    check("xtal", crystal_pins_dedicated, src > 3);
    check("pad_io", osc_input_pad_io, src == 2 || src == 3);
    check("pad_role", clock_out_pad_role, rc);
    check("od", clock_out_pad_open_drain, rc && !w1[0]);
    check("clk_out", clock_out_pad_drive_clock, rc && w1[0]);
    check("slow", slow_clock_khz, w2[11] ? 16 : 128);
    check("pkg", package_is_14pin, w2[10]);
    check("tag", customer_tag_field, w2[9:0]);
    n0 = ic_cnt;
    repeat (40) @(posedge mclk);
    check("instr", ic_cnt - n0, w0[10] ? 10 : 20);
  endtask : check_cfg
  task automatic configure(input logic [12:0] r0, input logic [12:0] r1, input logic [12:0] r2);
    raw0 <= r0;
    raw1 <= r1;
    raw2 <= r2;
    rst <= 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check_cfg(r0 | 13'h0080, r1 | 13'h0f80, r2 | 13'h1000);
    raw0 <= ~r0;
    raw1 <= ~r1;
    raw2 <= ~r2;
    repeat (4) @(posedge mclk);
    check_cfg(r0 | 13'h0080, r1 | 13'h0f80, r2 | 13'h1000);
  endtask : configure
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
    check("hresp", hresp, 0);
  endtask : ahb
  task automatic pulse(input int n);
    ext_int_pin <= 1'b0;
    repeat (n) @(posedge mclk);
    ext_int_pin <= 1'b1;
    repeat (50) @(posedge mclk);
  endtask : pulse
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    configure(13'h1fff, 13'h1fff, 13'h1fff);
    for (int i = 0; i < 16; i++) begin
      configure(rnd(), (rnd() & 13'h1fe1) | 13'(i << 1), rnd());
    end
    configure(13'h1fff, 13'h1fed, 13'h1fff);
    pulse(4);
    check("no_filter", ev_cnt, 1);
    for (int k = 0; k < 2; k++) begin
      configure(13'h1fef | 13'(k << 4), 13'h1fff, 13'h1fff);
      pulse(k ? 16 : 4);
      check("short", ev_cnt, 0);
      pulse(k ? 40 : 16);
      check("long", ev_cnt, 1);
    end
    ahb(1'b0, ADDR_INT_CTRL, 32'h0, rd);
    check("ctrl_rst", rd, 0);
    ahb(1'b0, ADDR_INT_STATUS, 32'h0, rd);
    check("masked", rd, 0);
    ahb(1'b1, ADDR_INT_CTRL, 32'hffffffff, rd);
    ahb(1'b0, ADDR_INT_CTRL, 32'h0, rd);
    check("ctrl", rd, 1);
    pulse(40);
    ahb(1'b0, ADDR_INT_STATUS, 32'h0, rd);
    check("flag", rd, 1);
    ahb(1'b1, ADDR_INT_STATUS, 32'h1, rd);
    ahb(1'b0, ADDR_INT_STATUS, 32'h0, rd);
    check("flag_clr", rd, 0);
    ahb(1'b0, ADDR_PIN_STATUS, 32'h0, rd);
    check("pin", rd, 3);
    ahb(1'b1, 8'h0c, 32'h5, rd);
    ahb(1'b0, 8'h0c, 32'h0, rd);
    check("unmapped", rd, 0);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    finish_test();
  end
endmodule : tb
